// *** sar_adc_conversion_control.v ***
`include "sar_ctrl_map.vh"
`default_nettype none

module sar_adc_conversion_control #(
    parameter PINS = 16
) (
    input wire mclk_in,
    input wire nrst_in,
    input wire converter_power_on_in,
    input wire [1:0] clock_select_low_in,
    input wire clock_select_high_in,
    input wire [2:0] channel_select_low_in,
    input wire channel_select_high_in,
    input wire result_justify_in,
    input wire start_set_in,
    input wire start_clear_in,
    input wire flag_clear_in,
    input wire result_high_wr_in,
    input wire result_low_wr_in,
    input wire [7:0] result_wr_data_in,
    input wire pin_cfg_wr_in,
    input wire [PINS-1:0] analog_select_wr_in,
    input wire [PINS-1:0] pin_direction_wr_in,
    input wire [PINS-1:0] pin_level_in,
    input wire rc_clk_in,
    input wire comparator_in,
    output reg conv_busy_out,
    output reg conv_complete_flag_out,
    output reg [7:0] result_high_byte_out,
    output reg [7:0] result_low_byte_out,
    output reg [PINS-1:0] analog_select_out,
    output reg [PINS-1:0] pin_direction_out,
    output reg [PINS-1:0] port_read_out,
    output reg sample_switch_closed_out,
    output reg [3:0] channel_out,
    output reg [9:0] dac_code_out,
    output reg converter_enable_out
);

// ----------------------------------------------------------------
// states and helpers
// ----------------------------------------------------------------
localparam [2:0] ST_ACQUIRE = 3'h1;
localparam [2:0] ST_CONVERT = 3'h2;
localparam [2:0] ST_RECOVER = 3'h4;

// terminal value of the divider for a given select code
function [5:0] div_term;
    input [2:0] sel;
    begin
        case (sel)
            `SEL_DIV2: div_term = `TERM_DIV2;
            `SEL_DIV4: div_term = `TERM_DIV4;
            `SEL_DIV8: div_term = `TERM_DIV8;
            `SEL_DIV16: div_term = `TERM_DIV16;
            `SEL_DIV32: div_term = `TERM_DIV32;
            `SEL_DIV64: div_term = `TERM_DIV64;
            default: div_term = `TERM_DIV2;
        endcase
    end
endfunction

wire [2:0] clock_select;
wire [3:0] channel_select;
assign clock_select = {clock_select_high_in, clock_select_low_in};
assign channel_select = {channel_select_high_in,
                         channel_select_low_in};

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
reg [PINS-1:0] pin_meta;
reg [PINS-1:0] pin_sync;
reg rc_meta;
reg rc_sync;
reg rc_prev;

always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        pin_meta <= {PINS{1'b0}};
        pin_sync <= {PINS{1'b0}};
        rc_meta <= 1'b0;
        rc_sync <= 1'b0;
        rc_prev <= 1'b0;
    end else begin
        pin_meta <= pin_level_in;
        pin_sync <= pin_meta;
        rc_meta <= rc_clk_in;
        rc_sync <= rc_meta;
        rc_prev <= rc_sync;
    end
end

// ----------------------------------------------------------------
// bit period tick
// ----------------------------------------------------------------
// the RC clock is far slower than mclk, so edge sampling loses
// nothing; the divider restarts whenever the converter is off
reg [5:0] div_cnt;
reg [2:0] state;
wire use_rc;
wire div_hit;
wire bit_tick;
wire abort_now;
assign use_rc = (clock_select[1:0] == `SEL_RC_LOW);
assign div_hit = (div_cnt >= div_term(clock_select));
assign bit_tick = use_rc ? (rc_sync & ~rc_prev) : div_hit;
// an abort lands anywhere in a bit period; restarting the divider
// there keeps the recovery gap a full two periods long
assign abort_now = (state == ST_CONVERT) && start_clear_in;

always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        div_cnt <= 6'h00;
    end else if (!converter_power_on_in || use_rc || div_hit ||
                 abort_now) begin
        div_cnt <= 6'h00;
    end else begin
        div_cnt <= div_cnt + 6'h01;
    end
end

// ----------------------------------------------------------------
// conversion sequencer
// ----------------------------------------------------------------
reg [2:0] next_state;
reg [3:0] step;
reg [3:0] next_step;
reg [9:0] sar;
reg [9:0] next_sar;
reg load_result;
reg set_flag;

always @* begin
    next_state = state;
    next_step = step;
    next_sar = sar;
    load_result = 1'b0;
    set_flag = 1'b0;
    case (state)
        ST_ACQUIRE: begin
            if (start_set_in && converter_power_on_in) begin
                next_state = ST_CONVERT;
                next_step = 4'h0;
                next_sar = 10'h200;
            end
        end
        ST_CONVERT: begin
            if (abort_now) begin
                next_state = ST_RECOVER;
                // the RC phase cannot be restarted, so one extra tick
                // is spent to make sure two whole periods pass
                next_step = use_rc ? `ABORT_RC_STEP : 4'h0;
            end else if (bit_tick) begin
                // step 0 settles the first trial, 1..10 decide bits
                if (step == `CONV_LAST_STEP) begin
                    load_result = 1'b1;
                    set_flag = 1'b1;
                    next_state = ST_RECOVER;
                    next_step = 4'h0;
                end else begin
                    next_step = step + 4'h1;
                    if (step >= 4'h1 && step <= 4'hA) begin
                        next_sar = sar;
                        if (!comparator_in) begin
                            next_sar[4'hA - step] = 1'b0;
                        end
                        if (step != 4'hA) begin
                            next_sar[4'h9 - step] = 1'b1;
                        end
                    end
                end
            end
        end
        ST_RECOVER: begin
            if (bit_tick) begin
                // a step left at the abort value wraps to zero here
                if (step == `RECOV_LAST_STEP) begin
                    next_state = ST_ACQUIRE;
                    next_step = 4'h0;
                end else begin
                    next_step = step + 4'h1;
                end
            end
        end
        default: begin
            next_state = ST_ACQUIRE;
            next_step = 4'h0;
        end
    endcase
end

always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        state <= ST_ACQUIRE;
        step <= 4'h0;
        sar <= 10'h000;
    end else if (!converter_power_on_in) begin
        // losing power drops a conversion at once; result and flag stay
        state <= ST_ACQUIRE;
        step <= 4'h0;
        sar <= 10'h000;
    end else begin
        state <= next_state;
        step <= next_step;
        sar <= next_sar;
    end
end

// ----------------------------------------------------------------
// start/done bit and completion flag
// ----------------------------------------------------------------
always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        conv_busy_out <= 1'b0;
        conv_complete_flag_out <= 1'b0;
    end else begin
        conv_busy_out <= (next_state == ST_CONVERT) &&
                         converter_power_on_in;
        // a completion in the clearing cycle wins over the clear
        if (set_flag && converter_power_on_in) begin
            conv_complete_flag_out <= 1'b1;
        end else if (flag_clear_in) begin
            conv_complete_flag_out <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// result pair
// ----------------------------------------------------------------
// software writes keep working while the converter is off, so the
// pair doubles as two plain byte registers
always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        result_high_byte_out <= `RESULT_RESET;
        result_low_byte_out <= `RESULT_RESET;
    end else if (load_result && converter_power_on_in) begin
        if (result_justify_in) begin
            result_high_byte_out <= {6'h00, next_sar[9:8]};
            result_low_byte_out <= next_sar[7:0];
        end else begin
            result_high_byte_out <= next_sar[9:2];
            result_low_byte_out <= {next_sar[1:0], 6'h00};
        end
    end else begin
        // an abort never reaches here with a partial value
        if (result_high_wr_in) begin
            result_high_byte_out <= result_wr_data_in;
        end
        if (result_low_wr_in) begin
            result_low_byte_out <= result_wr_data_in;
        end
    end
end

// ----------------------------------------------------------------
// pin configuration and port reads
// ----------------------------------------------------------------
// reads are masked with the setup that takes effect at this edge, so
// a pin just turned analog never shows its level for a cycle
wire [PINS-1:0] next_analog_select;
assign next_analog_select = pin_cfg_wr_in ? analog_select_wr_in :
                            analog_select_out;

always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        analog_select_out <= `ANALOG_SEL_RESET;
        pin_direction_out <= `PIN_DIR_RESET;
        port_read_out <= {PINS{1'b0}};
    end else begin
        if (pin_cfg_wr_in) begin
            analog_select_out <= analog_select_wr_in;
            pin_direction_out <= pin_direction_wr_in;
        end
        port_read_out <= pin_sync & ~next_analog_select;
    end
end

// ----------------------------------------------------------------
// analog front end controls
// ----------------------------------------------------------------
// the channel mux ignores direction and analog/digital setup, so a
// driven or digital pin is converted like any other
always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        sample_switch_closed_out <= 1'b0;
        channel_out <= 4'h0;
        dac_code_out <= 10'h000;
        converter_enable_out <= 1'b0;
    end else begin
        converter_enable_out <= converter_power_on_in;
        channel_out <= channel_select;
        // no discharge path exists: an open switch just holds charge
        sample_switch_closed_out <= converter_power_on_in &&
            (next_state == ST_ACQUIRE);
        dac_code_out <= next_sar;
    end
end

endmodule

`default_nettype wire

// *** sar_ctrl_map.vh ***
// Overview of operation
// - completion loads result, clears start, sets flag
// - start runs twelve bit periods of conversion
// - sampling switch opens for whole conversion
// - switch stays open two periods after completion
// - clock select code picks divider or RC
// - port read gives zero on analog pins
// - reset makes shared pins analog inputs
// - output-driven analog pin still converted
// - digital-configured selected pin still converted
// - clearing start aborts, result pair untouched
// - abort waits two periods then reacquires
// - holding capacitor never discharged between conversions
// - power bit gates converter and start bit
// - clock select split over two control registers
// - justify bit aligns result right or left
// - four-bit channel select, sixteen inputs
`ifndef SAR_CTRL_MAP_VH
`define SAR_CTRL_MAP_VH

// ----------------------------------------------------------------
// clock select codes and divider terminal counts
// ----------------------------------------------------------------
`define SEL_DIV2 3'h0
`define SEL_DIV4 3'h4
`define SEL_DIV8 3'h1
`define SEL_DIV16 3'h5
`define SEL_DIV32 3'h2
`define SEL_DIV64 3'h6
`define SEL_RC_LOW 2'h3
`define TERM_DIV2 6'h01
`define TERM_DIV4 6'h03
`define TERM_DIV8 6'h07
`define TERM_DIV16 6'h0F
`define TERM_DIV32 6'h1F
`define TERM_DIV64 6'h3F

// ----------------------------------------------------------------
// sequence counts, in bit periods
// ----------------------------------------------------------------
`define CONV_LAST_STEP 4'hB
`define RECOV_LAST_STEP 4'h1
`define ABORT_RC_STEP 4'hF

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ANALOG_SEL_RESET 16'hFFFF
`define PIN_DIR_RESET 16'hFFFF
`define RESULT_RESET 8'h00

`endif

// *** adc_ctrl_sva.sv ***
`default_nettype none
module adc_ctrl_sva #(parameter int PINS = 16) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic converter_power_on_in,
    input wire logic [1:0] clock_select_low_in,
    input wire logic clock_select_high_in,
    input wire logic result_justify_in,
    input wire logic start_set_in,
    input wire logic start_clear_in,
    input wire logic result_high_wr_in,
    input wire logic result_low_wr_in,
    input wire logic conv_busy_out,
    input wire logic conv_complete_flag_out,
    input wire logic [7:0] result_high_byte_out,
    input wire logic [7:0] result_low_byte_out,
    input wire logic [PINS-1:0] analog_select_out,
    input wire logic [PINS-1:0] port_read_out,
    input wire logic sample_switch_closed_out,
    input wire logic converter_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] busy_len;
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    // restarted by each accepted start, so refused starts cannot skew it
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_len <= 10'h000;
        end else if (start_set_in && !conv_busy_out) begin
            busy_len <= 10'h000;
        end else if (conv_busy_out) begin
            busy_len <= busy_len + 10'h001;
        end
    end
    a_start_sets_busy: assert property (
        start_set_in && !start_clear_in && converter_power_on_in &&
        sample_switch_closed_out |=> conv_busy_out)
        else $error("start not taken");
    a_switch_open_busy: assert property (
        conv_busy_out |-> !sample_switch_closed_out)
        else $error("switch closed while converting");
    a_done_sets_flag: assert property ($fell(conv_busy_out) &&
        !$past(start_clear_in) && $past(converter_power_on_in)
        |-> conv_complete_flag_out) else $error("flag not set");
    a_abort_keeps_result: assert property (start_clear_in &&
        conv_busy_out && !result_high_wr_in && !result_low_wr_in
        |=> !conv_busy_out && $stable(result_high_byte_out) &&
        $stable(result_low_byte_out) && !$rose(conv_complete_flag_out))
        else $error("abort changed result");
    a_recovery_gap: assert property ($fell(conv_busy_out)
        |-> !sample_switch_closed_out [*3]) else $error("early reacquire");
    a_analog_reads_zero: assert property (
        (port_read_out & analog_select_out) == '0)
        else $error("analog pin read nonzero");
    a_power_gates: assert property (!converter_power_on_in
        |=> !conv_busy_out && !converter_enable_out)
        else $error("converter active unpowered");
    a_conv_length: assert property ($rose(conv_complete_flag_out) &&
        {clock_select_high_in, clock_select_low_in} == 3'h0
        |-> busy_len inside {[10'd21:10'd28]}) else $error("bad length");
    a_result_justify: assert property ($rose(conv_complete_flag_out)
        |-> ($past(result_justify_in) ? result_high_byte_out[7:2] == 6'h00
        : result_low_byte_out[5:0] == 6'h00)) else $error("bad padding");
endmodule
`default_nettype wire

// *** analog_front_model.sv ***
`default_nettype none
module analog_front_model (
    input wire logic mclk_in,
    input wire logic sample_switch_closed_in,
    input wire logic [3:0] channel_in,
    input wire logic [9:0] dac_code_in,
    input wire logic [9:0] level_in [16],
    output logic comparator_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held = 10'h000;
    // charge is held, not bled off, while the switch is open
    always @(posedge mclk_in) begin
        if (sample_switch_closed_in) begin
            held <= level_in[channel_in];
        end
    end
    // settles at once, as a front end given a long enough bit period
    assign comparator_out = (dac_code_in <= held);
endmodule
`default_nettype wire

// *** sar_adc_conversion_control_test.sv ***
`default_nettype none
module sar_adc_conversion_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0, nrst_in = 1'b0, converter_power_on_in = 1'b0;
    logic clock_select_high_in = 1'b0, channel_select_high_in = 1'b0;
    logic [1:0] clock_select_low_in = 2'h0;
    logic [2:0] channel_select_low_in = 3'h0;
    logic result_justify_in = 1'b0, rc_clk_in = 1'b0, comparator_in;
    logic [7:0] result_wr_data_in = 8'h00;
    logic [15:0] analog_select_wr_in = 16'h0000, pin_level_in = 16'h0000;
    logic [15:0] pin_direction_wr_in = 16'h0000, lfsr = 16'h003C;
    logic [5:0] strobes = 6'h00;
    wire start_set_in, start_clear_in, flag_clear_in, pin_cfg_wr_in;
    wire result_high_wr_in, result_low_wr_in;
    logic conv_busy_out, conv_complete_flag_out, sample_switch_closed_out;
    logic converter_enable_out;
    logic [7:0] result_high_byte_out, result_low_byte_out;
    logic [15:0] analog_select_out, pin_direction_out, port_read_out;
    logic [3:0] channel_out;
    logic [9:0] dac_code_out;
    logic [9:0] levels [16] = '{default: 10'h000};
    logic [2:0] codes [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int ns [8] = '{2, 4, 8, 16, 32, 64, 7, 7};
    int errors = 0, samples_checked = 0, len;
    assign {start_set_in, start_clear_in, flag_clear_in, result_high_wr_in,
        result_low_wr_in, pin_cfg_wr_in} = strobes;
    sar_adc_conversion_control dut (.*);
    analog_front_model front (.mclk_in(mclk_in), .channel_in(channel_out),
        .sample_switch_closed_in(sample_switch_closed_out),
        .dac_code_in(dac_code_out), .level_in(levels),
        .comparator_out(comparator_in));
    initial forever #5 mclk_in = ~mclk_in;
    // kept off the mclk edges so the synchroniser never sees a race
    initial #2 forever #35 rc_clk_in = ~rc_clk_in;
    function logic [15:0] next_rand();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    function automatic logic [15:0] justify(input logic [9:0] v,
        input logic j);
        return j ? {6'h00, v} : {v, 6'h00};
    endfunction
    task check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task check_len(input int n, input int lo, input int hi);
        samples_checked++;
        if (n < lo || n > hi) begin
            errors++;
            $display("Error at %0t: span %0d outside %0d..%0d",
                $time, n, lo, hi);
        end
    endtask
    task pulse(input logic [5:0] m);
        @(posedge mclk_in);
        strobes <= m;
        @(posedge mclk_in);
        strobes <= 6'h00;
    endtask
    task convert(input logic [2:0] code, input int n, input logic [9:0] v);
        logic [3:0] ch;
        ch = next_rand() % 16;
        levels[ch] = v;
        @(posedge mclk_in);
        {clock_select_high_in, clock_select_low_in} <= code;
        {channel_select_high_in, channel_select_low_in} <= ch;
        result_justify_in <= lfsr[4];
        pulse(6'h08);
        #1;
        check({15'h0000, conv_complete_flag_out}, 16'h0000);
        // acquisition time passes before the start bit is set
        len = 0;
        while (sample_switch_closed_out !== 1'b1 && len < 2000) begin
            @(posedge mclk_in);
            #1;
            len++;
        end
        repeat (8) @(posedge mclk_in);
        pulse(6'h20);
        #1;
        len = 0;
        while (conv_busy_out === 1'b1 && len < 2000) begin
            @(posedge mclk_in);
            #1;
            len++;
        end
        check_len(len, 11 * n, 12 * n + 4);
        check({12'h000, channel_out}, {12'h000, ch});
        check({result_high_byte_out, result_low_byte_out},
            justify(v, result_justify_in));
        check({15'h0000, conv_complete_flag_out}, 16'h0001);
    endtask
    task final_report();
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        errors++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(posedge mclk_in);
        #1;
        check(analog_select_out, 16'hFFFF);
        check(pin_direction_out, 16'hFFFF);
        check({result_high_byte_out, result_low_byte_out}, 16'h0000);
        @(posedge mclk_in);
        converter_power_on_in <= 1'b1;
        analog_select_wr_in <= next_rand();
        pin_direction_wr_in <= next_rand();
        pin_level_in <= next_rand();
        pulse(6'h01);
        repeat (6) @(posedge mclk_in);
        result_wr_data_in <= 8'hA5;
        #1;
        check(port_read_out, pin_level_in & ~analog_select_wr_in);
        check(pin_direction_out, pin_direction_wr_in);
        pulse(6'h04);
        result_wr_data_in <= 8'h5A;
        pulse(6'h02);
        repeat (8) @(posedge mclk_in);
        pulse(6'h20);
        repeat (9) @(posedge mclk_in);
        pulse(6'h10);
        #1;
        check({result_high_byte_out, result_low_byte_out}, 16'hA55A);
        check({14'h0, conv_busy_out, conv_complete_flag_out}, 16'h0);
        len = 0;
        while (sample_switch_closed_out !== 1'b1 && len < 100) begin
            @(posedge mclk_in);
            #1;
            len++;
        end
        check_len(len, 2, 6);
        for (int i = 0; i < 8; i++) begin
            convert(codes[i], ns[i], (i == 0) ? 10'h3FF : (i == 1) ? 10'h000
                : next_rand() % 1024);
        end
        // a second reset in mid-run must bring every shared pin back
        @(posedge mclk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
        #1;
        check(analog_select_out, 16'hFFFF);
        check(pin_direction_out, 16'hFFFF);
        @(posedge mclk_in);
        converter_power_on_in <= 1'b0;
        pulse(6'h20);
        #1;
        check({14'h0, conv_busy_out, converter_enable_out}, 16'h0);
        final_report();
    end
endmodule
bind sar_adc_conversion_control adc_ctrl_sva #(.PINS(PINS)) chk (.*);
`default_nettype wire
